// ==== capture_model.sv ====
`timescale 1ns/1ns

// Receiving capture logic: takes channel A on strobe rise, channel B on fall
module capture_model (
	input  wire logic       strobe,
	input  wire logic [9:0] bits,
	input  wire logic       ovr,
	output logic      [9:0] word_a,
	output logic            or_a,
	output logic      [9:0] word_b,
	output logic            or_b,
	output logic            pair_tgl
);
	// Set by a rise, so a fall is only taken after its A half
	logic armed;

	// Start disarmed so the reset edge on the strobe is not taken
	initial begin
		armed    = 1'b0;
		pair_tgl = 1'b0;
	end

	// Channel A half, clocked by the strobe and no other clock
	always @(posedge strobe) begin
		word_a = bits;
		or_a   = ovr;
		armed  = 1'b1;
	end

	// Channel B half; completes one merged pair for the bench
	always @(negedge strobe) begin
		if (armed) begin
			word_b   = bits;
			or_b     = ovr;
			armed    = 1'b0;
			pair_tgl = ~pair_tgl;
		end
	end
endmodule : capture_model

// ==== ddr_output_port.sv ====
`timescale 1ns/1ns

// What this block does
// - Twelve differential outputs: word, strobe, over-range.
// - Word carries converted value of presented channel.
// - Over-range high when sample exceeds word range.
// - Strobe travels with data; receiver captures by it.
// - Outputs valid only while power-down is low.
// - Mid-scale reads 10_0000_0000 or 00_0000_0000 by format.
module ddr_output_port #(
	parameter int SAMPLE_W = ddr_port_pkg::SAMPLE_W,
	parameter int RAW_W    = ddr_port_pkg::RAW_W
) (
	input  wire logic                    clk,
	input  wire logic                    clk_en,
	input  wire logic                    rst_b,
	input  wire logic                    link_clk,
	input  wire logic                    power_down_input,
	input  wire logic                    format_stabilizer_select,
	input  wire logic                    src_valid,
	output logic                         src_ready,
	input  wire logic signed [RAW_W-1:0] raw_a,
	input  wire logic signed [RAW_W-1:0] raw_b,
	output logic         [SAMPLE_W-1:0]  sample_bits_p,
	output logic         [SAMPLE_W-1:0]  sample_bits_n,
	output logic                         over_range_p,
	output logic                         over_range_n,
	output logic                         data_ready_strobe_p,
	output logic                         data_ready_strobe_n
);

	// Clamp a raw code into the word; top bit is the over-range flag
	function automatic logic [SAMPLE_W:0] clamp_code(input logic signed [RAW_W-1:0] raw);
		logic [SAMPLE_W:0] res;
		res = {1'b0, raw[SAMPLE_W-1:0]};
		if (raw > ddr_port_pkg::RAW_MAX) begin
			res = {1'b1, ddr_port_pkg::WORD_POS_FS};
		end else if (raw < ddr_port_pkg::RAW_MIN) begin
			res = {1'b1, ddr_port_pkg::WORD_NEG_FS};
		end
		return res;
	endfunction : clamp_code

	// Offset binary is two's complement with the top bit inverted
	function automatic logic [SAMPLE_W-1:0] fmt_word(input logic [SAMPLE_W-1:0] w,
	                                               input logic twos);
		return twos ? w : {~w[SAMPLE_W-1], w[SAMPLE_W-2:0]};
	endfunction : fmt_word

	// ---------------- Core clock domain ----------------

	logic                rst_meta_r;  // Reset release, first stage
	logic                rst_q_r;     // Reset release, used by core logic
	logic                req_r;       // Toggles once per handed-over pair
	logic                ack_lvl;     // Acknowledge toggle after crossing
	logic [SAMPLE_W-1:0] hold_a_r;    // Channel A word, two's complement
	logic [SAMPLE_W-1:0] hold_b_r;    // Channel B word, two's complement
	logic                hold_ora_r;  // Channel A over-range
	logic                hold_orb_r;  // Channel B over-range
	logic [SAMPLE_W:0]   clamp_a;     // Clamped channel A with flag
	logic [SAMPLE_W:0]   clamp_b;     // Clamped channel B with flag
	logic                src_fire;    // Pair accepted this cycle
	logic                ack_r;       // Acknowledge toggle, driven by the link side

	// Reset is released through two flip-flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_r <= 1'b0;
			rst_q_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_q_r    <= rst_meta_r;
		end
	end

	// Acknowledge toggle from the link side
	sync_stage #(.W(1)) u_ack_sync (
		.clk   (clk),
		.rst_b (rst_q_r),
		.en    (clk_en),
		.d     (ack_r),
		.q     (ack_lvl)
	);

	assign clamp_a   = clamp_code(raw_a);
	assign clamp_b   = clamp_code(raw_b);
	assign src_ready = (req_r == ack_lvl);
	assign src_fire  = src_valid && src_ready && clk_en;

	// Capture a pair and announce it to the link side
	always_ff @(posedge clk or negedge rst_q_r) begin
		if (!rst_q_r) begin
			req_r      <= ddr_port_pkg::TOGGLE_RST;
			hold_a_r   <= ddr_port_pkg::WORD_RST;
			hold_b_r   <= ddr_port_pkg::WORD_RST;
			hold_ora_r <= ddr_port_pkg::FLAG_RST;
			hold_orb_r <= ddr_port_pkg::FLAG_RST;
		end else if (src_fire) begin
			req_r      <= ~req_r;
			hold_a_r   <= clamp_a[SAMPLE_W-1:0];
			hold_b_r   <= clamp_b[SAMPLE_W-1:0];
			hold_ora_r <= clamp_a[SAMPLE_W];
			hold_orb_r <= clamp_b[SAMPLE_W];
		end
	end

	// Positive out-of-range raw code on channel A sets the flag and saturates the word high
	over_range_a: assert property (@(posedge clk) disable iff (!rst_q_r)
		src_fire && (raw_a > ddr_port_pkg::RAW_MAX)
		|=> hold_ora_r && (hold_a_r == ddr_port_pkg::WORD_POS_FS))
		else $error("over-range not flagged for channel A");

	// ---------------- Link clock domain ----------------

	logic                lrst_meta_r; // Link reset release, first stage
	logic                lrst_q_r;    // Link reset, used by link logic
	logic                req_lvl;     // Request toggle after crossing
	logic [1:0]          pin_lvl;     // Power-down and format after crossing
	logic                pd_lvl;      // Power-down level
	logic                fmt_lvl;     // High selects two's complement
	logic                new_pair;    // A pair waits in the hold registers
	logic                take;        // Pair taken into the output path
	logic                ack_nxt;
	ddr_port_pkg::link_state_t state_r; // Strobe phase
	ddr_port_pkg::link_state_t state_nxt;
	logic [SAMPLE_W-1:0] bits_r;      // Word on the pins
	logic [SAMPLE_W-1:0] bits_nxt;
	logic                orv_r;       // Over-range on the pins
	logic                orv_nxt;
	logic                strobe_r;    // Data-ready strobe on the pins
	logic                strobe_nxt;
	logic [SAMPLE_W-1:0] wb_r;        // Channel B word waiting for its half
	logic [SAMPLE_W-1:0] wb_nxt;
	logic                worb_r;      // Channel B over-range waiting
	logic                worb_nxt;

	// Link reset is released through two flip-flops
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			lrst_meta_r <= 1'b0;
			lrst_q_r    <= 1'b0;
		end else begin
			lrst_meta_r <= 1'b1;
			lrst_q_r    <= lrst_meta_r;
		end
	end

	// Request toggle from the core side
	sync_stage #(.W(1)) u_req_sync (
		.clk   (link_clk),
		.rst_b (lrst_q_r),
		.en    (1'b1),
		.d     (req_r),
		.q     (req_lvl)
	);

	// Power-down and format pins
	sync_stage #(.W(2)) u_pin_sync (
		.clk   (link_clk),
		.rst_b (lrst_q_r),
		.en    (1'b1),
		.d     ({power_down_input, format_stabilizer_select}),
		.q     (pin_lvl)
	);

	assign pd_lvl   = pin_lvl[1];
	assign fmt_lvl  = pin_lvl[0];
	assign new_pair = (req_lvl != ack_r);
	assign take     = new_pair && !pd_lvl
	                  && ((state_r == ddr_port_pkg::ST_IDLE)
	                  || (state_r == ddr_port_pkg::ST_B_LOW));

	// Next phase of the strobe and data pins
	always_comb begin
		state_nxt  = state_r;
		bits_nxt   = bits_r;
		orv_nxt    = orv_r;
		strobe_nxt = strobe_r;
		ack_nxt    = ack_r;
		wb_nxt     = wb_r;
		worb_nxt   = worb_r;
		if (pd_lvl) begin
			// Powered down: pins quiet, pending pairs are dropped
			state_nxt  = ddr_port_pkg::ST_IDLE;
			bits_nxt   = ddr_port_pkg::WORD_RST;
			orv_nxt    = ddr_port_pkg::FLAG_RST;
			strobe_nxt = 1'b0;
			ack_nxt    = req_lvl;
		end else begin
			case (state_r)
				ddr_port_pkg::ST_IDLE, ddr_port_pkg::ST_B_LOW: begin
					// Channel A goes out one cycle before the rise
					if (take) begin
						bits_nxt  = fmt_word(hold_a_r, fmt_lvl);
						orv_nxt   = hold_ora_r;
						wb_nxt    = fmt_word(hold_b_r, fmt_lvl);
						worb_nxt  = hold_orb_r;
						ack_nxt   = req_lvl;
						state_nxt = ddr_port_pkg::ST_A_LEAD;
					end else begin
						state_nxt = ddr_port_pkg::ST_IDLE;
					end
				end
				ddr_port_pkg::ST_A_LEAD: begin
					// Rise marks channel A
					strobe_nxt = 1'b1;
					state_nxt  = ddr_port_pkg::ST_A_HIGH;
				end
				ddr_port_pkg::ST_A_HIGH: begin
					// Channel B goes out one cycle before the fall
					bits_nxt  = wb_r;
					orv_nxt   = worb_r;
					state_nxt = ddr_port_pkg::ST_B_LEAD;
				end
				ddr_port_pkg::ST_B_LEAD: begin
					// Fall marks channel B
					strobe_nxt = 1'b0;
					state_nxt  = ddr_port_pkg::ST_B_LOW;
				end
				default: begin
					state_nxt = ddr_port_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Link state registers
	always_ff @(posedge link_clk or negedge lrst_q_r) begin
		if (!lrst_q_r) begin
			state_r  <= ddr_port_pkg::ST_IDLE;
			bits_r   <= ddr_port_pkg::WORD_RST;
			orv_r    <= ddr_port_pkg::FLAG_RST;
			strobe_r <= 1'b0;
			ack_r    <= ddr_port_pkg::TOGGLE_RST;
			wb_r     <= ddr_port_pkg::WORD_RST;
			worb_r   <= ddr_port_pkg::FLAG_RST;
		end else begin
			state_r  <= state_nxt;
			bits_r   <= bits_nxt;
			orv_r    <= orv_nxt;
			strobe_r <= strobe_nxt;
			ack_r    <= ack_nxt;
			wb_r     <= wb_nxt;
			worb_r   <= worb_nxt;
		end
	end

	// Differential pin pairs
	assign sample_bits_p       = bits_r;
	assign sample_bits_n       = ~bits_r;
	assign over_range_p        = orv_r;
	assign over_range_n        = ~orv_r;
	assign data_ready_strobe_p = strobe_r;
	assign data_ready_strobe_n = ~strobe_r;

	// Both legs of every pair are complementary
	pair_invert_a: assert property (@(posedge link_clk) disable iff (!lrst_q_r)
		(sample_bits_n == ~sample_bits_p) && (over_range_n != over_range_p)
		&& (data_ready_strobe_n != data_ready_strobe_p))
		else $error("differential legs not complementary");

	// Word for A at the rise, word for B at the fall
	word_carry_a: assert property (@(posedge link_clk) disable iff (!lrst_q_r || pd_lvl)
		take |=> (sample_bits_p == fmt_word($past(hold_a_r), $past(fmt_lvl)))
		##2 (sample_bits_p == fmt_word($past(hold_b_r, 3), $past(fmt_lvl, 3))))
		else $error("pin word does not match the channel presented");

	// Strobe stays high two cycles with data steady over each edge
	sequence s_high_two;
		data_ready_strobe_p [*2];
	endsequence
	sequence s_fall_steady;
		!data_ready_strobe_p && $stable(sample_bits_p);
	endsequence
	strobe_shape_a: assert property (@(posedge link_clk) disable iff (!lrst_q_r || pd_lvl)
		$rose(data_ready_strobe_p) |-> $stable(sample_bits_p) and (s_high_two ##1 s_fall_steady))
		else $error("strobe shape or data stability wrong");

	// Power-down silences the pins
	pd_quiet_a: assert property (@(posedge link_clk) disable iff (!lrst_q_r)
		pd_lvl |=> !data_ready_strobe_p && (sample_bits_p == ddr_port_pkg::WORD_RST)
		&& !over_range_p)
		else $error("pins active while powered down");

	// Mid-scale code in the selected format, offset binary or two's complement
	mid_scale_a: assert property (@(posedge link_clk) disable iff (!lrst_q_r || pd_lvl)
		take && (hold_a_r == ddr_port_pkg::MID_TWOS_COMP)
		|=> (sample_bits_p == ($past(fmt_lvl) ? ddr_port_pkg::MID_TWOS_COMP
		                                      : ddr_port_pkg::MID_OFFSET_BIN)))
		else $error("mid-scale word wrong for the selected format");

	// Strobe rises two link cycles after a take and falls two cycles later
	strobe_timing_a: assert property (@(posedge link_clk) disable iff (!lrst_q_r || pd_lvl)
		take |=> !data_ready_strobe_p ##1 data_ready_strobe_p [*2] ##1 !data_ready_strobe_p)
		else $error("strobe edges not at the expected link cycles");

	// Negative out-of-range code on channel B saturates low and flags
	neg_clamp_a: assert property (@(posedge clk) disable iff (!rst_q_r)
		src_fire && (raw_b < ddr_port_pkg::RAW_MIN)
		|=> hold_orb_r && (hold_b_r == ddr_port_pkg::WORD_NEG_FS))
		else $error("over-range not flagged for channel B");

	// Held words stay put: no new pair until the link acknowledges
	hold_guard_a: assert property (@(posedge clk) disable iff (!rst_q_r)
		src_fire |=> !src_ready)
		else $error("new pair accepted while one is in flight");

endmodule : ddr_output_port

// ==== ddr_port_pkg.sv ====
package ddr_port_pkg;

	// Width of the sample word on the output pins
	localparam int SAMPLE_W = 10;
	// Width of the signed raw code coming from the converter core
	localparam int RAW_W    = 12;

	// Largest and smallest raw code that fits the 10-bit word
	localparam logic signed [11:0] RAW_MAX = 12'sh1FF;
	localparam logic signed [11:0] RAW_MIN = 12'shE00;

	// Saturated two's complement words used on over-range
	localparam logic [9:0] WORD_POS_FS = 10'h1FF;
	localparam logic [9:0] WORD_NEG_FS = 10'h200;

	// Mid-scale word in offset binary and two's complement
	localparam logic [9:0] MID_OFFSET_BIN = 10'h200;
	localparam logic [9:0] MID_TWOS_COMP  = 10'h000;

	// Reset values of the output pins and of the handshake toggles
	localparam logic [9:0] WORD_RST   = 10'h000;
	localparam logic       FLAG_RST   = 1'h0;
	localparam logic       TOGGLE_RST = 1'h0;

	// Link clock cycles from a load to the strobe rise and fall
	localparam int LEAD_TO_RISE = 2;
	localparam int LEAD_TO_FALL = 4;

	// Phases of one strobe period on the link side
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_A_LEAD,
		ST_A_HIGH,
		ST_B_LEAD,
		ST_B_LOW
	} link_state_t;

endpackage : ddr_port_pkg

// ==== dual_adc_ddr_output_port_tb.sv ====
`timescale 1ns/1ns

// Self-checking bench for the converter output port
module dual_adc_ddr_output_port_tb;
	logic               clk, clk_en, rst_b, link_clk, pd, fmt, src_valid;
	logic signed [11:0] raw_a, raw_b;
	logic               src_ready, orp, orn, stp, stn;
	logic        [9:0]  sp, sn;
	logic        [9:0]  wa, wb;
	logic               oa, ob, tgl;
	logic        [21:0] exp_q[$];
	int                 n_errors = 0;
	int                 n_compared = 0;
	int                 cycles = 0;

	ddr_output_port dut_u (
		.clk(clk), .clk_en(clk_en), .rst_b(rst_b), .link_clk(link_clk),
		.power_down_input(pd), .format_stabilizer_select(fmt),
		.src_valid(src_valid), .src_ready(src_ready), .raw_a(raw_a), .raw_b(raw_b),
		.sample_bits_p(sp), .sample_bits_n(sn), .over_range_p(orp), .over_range_n(orn),
		.data_ready_strobe_p(stp), .data_ready_strobe_n(stn)
	);

	capture_model cap_u (
		.strobe(stp), .bits(sp), .ovr(orp), .word_a(wa), .or_a(oa),
		.word_b(wb), .or_b(ob), .pair_tgl(tgl)
	);

	// Core clock, 40 ns period
	always #20 clk = ~clk;

	// Link clock, 48 ns period, offset from the core clock
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end

	// Cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	// Counts and reports one comparison
	task check(input logic [21:0] seen, input logic [21:0] want);
		n_compared++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check

	// Over-range bit and formatted word for one raw code
	function automatic logic [10:0] expect_w(input logic signed [11:0] r);
		logic       o;
		logic [9:0] w;
		o = (r > ddr_port_pkg::RAW_MAX) || (r < ddr_port_pkg::RAW_MIN);
		w = o ? (r[11] ? ddr_port_pkg::WORD_NEG_FS : ddr_port_pkg::WORD_POS_FS) : r[9:0];
		w[9] = w[9] ^ ~fmt;
		return {o, w};
	endfunction : expect_w

	// Mostly in-range codes, one in four over the full raw span
	function automatic logic signed [11:0] rnd();
		if ($urandom % 4 == 0)
			return 12'($urandom);
		return 12'(int'($urandom % 1024) - 512);
	endfunction : rnd

	// Offers one pair, holding it while refused, with random core enable
	task send(input logic signed [11:0] a, input logic signed [11:0] b);
		logic took;
		took = 1'b0;
		src_valid = 1'b1;
		raw_a = a;
		raw_b = b;
		while (!took) begin
			@(negedge clk);
			took = (src_ready === 1'b1) && (clk_en === 1'b1);
			@(posedge clk);
			#1;
			clk_en = ($urandom % 4) != 0;
		end
		if (!pd)
			exp_q.push_back({expect_w(a), expect_w(b)});
	endtask : send

	// Boundary pairs, then random back-to-back pairs, then drain
	task batch(input int n);
		send(12'sh000, 12'sh000);
		send(12'sh1FF, 12'shE00);
		send(12'sh200, 12'shDFF);
		send(12'sh7FF, 12'sh800);
		repeat (n) send(rnd(), rnd());
		src_valid = 1'b0;
		clk_en = 1'b1;
		repeat (80) @(posedge clk);
		#1;
		check(22'(exp_q.size()), 22'h0);
		check(22'(src_ready), 22'h1);
	endtask : batch

	// Prints the counts and the verdict, then ends the run
	task wrap_up;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// Compares each captured pair with the oldest note once the pins settle;
	// starts after time zero so the model's power-up value is no pair
	initial begin
		#1;
		forever begin
			@(tgl);
			#1;
			if (exp_q.size() == 0)
				check(22'h1, 22'h0);
			else
				check({oa, wa, ob, wb}, exp_q.pop_front());
			check(22'({sn, orn, stn}), 22'({~sp, ~orp, ~stp}));
		end
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		clk_en = 1'b1;
		pd = 1'b0;
		fmt = 1'b0;
		src_valid = 1'b0;
		raw_a = 12'sh000;
		raw_b = 12'sh000;
		void'($urandom(58));
		repeat (10) @(posedge clk);
		#1;
		rst_b = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		batch(25);
		fmt = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		batch(25);
		pd = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		check(22'({sp, orp, stp}), 22'h0);
		send(rnd(), rnd());
		send(rnd(), rnd());
		src_valid = 1'b0;
		repeat (40) @(posedge clk);
		#1;
		check(22'({sp, orp, stp}), 22'h0);
		pd = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		batch(10);
		wrap_up();
	end
endmodule : dual_adc_ddr_output_port_tb

// ==== sync_stage.sv ====
`timescale 1ns/1ns

// Three-stage synchroniser; output moves once stages two and three agree
module sync_stage #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;   // First stage, read by stage two only
	logic [W-1:0] stage2_r; // Second stage
	logic [W-1:0] stage3_r; // Third stage
	logic [W-1:0] q_r;      // Filtered level

	// Shift chain and agreement filter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r   <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			q_r      <= '0;
		end else if (en) begin
			meta_r   <= d;
			stage2_r <= meta_r;
			stage3_r <= stage2_r;
			// Accept a change only when two stages agree
			if (stage2_r == stage3_r) begin
				q_r <= stage3_r;
			end
		end
	end

	assign q = q_r;

endmodule : sync_stage
